// file: lsp_chk.sv
// concurrent checks on the lane sample packer ports
`timescale 1ns/10ps
module lsp_chk (
    input wire         clk,
    input wire         rst,
    input wire [3:0]   lane_map_mode,
    input wire         dual_channel_pin,
    input wire [511:0] lane_data,
    input wire [7:0]   lane_enable,
    input wire         frame_valid,
    input wire         frame_ready,
    input wire         mode_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [3:0]   m  = lane_map_mode;
    wire         ok = m > 4'ha && m < 4'he;
    wire         sg = !dual_channel_pin;
    wire [511:0] d  = lane_data;
    // mode must be settled for three cycles so a frame was built in it
    sequence fresh(x);
        $rose(frame_valid) && m == x && $past(m, 3) == x;
    endsequence
    mode_err_a: assert property ((!ok)[*2] |-> mode_error) else $error("no mode error");
    off_a: assert property ((!ok)[*3] |-> lane_enable == 8'h00 && !$rose(frame_valid))
        else $error("lanes active in bad mode");
    pad11_a: assert property (fresh(4'hb) |-> !(d & {8{64'h0070_0700_7007_007f}}))
        else $error("mode 11 pad or tail set");
    en_dual_a: assert property ((ok && !sg)[*5] |-> lane_enable == 8'hff)
        else $error("dual lanes not enabled");
    pad12_a: assert property (fresh(4'hc) |-> !(d & {8{64'hffff_ffff_ffff_ff00}}))
        else $error("mode 12 upper bits set");
    pad13_a: assert property (fresh(4'hd) |-> !(d & {8{64'hffff_ff00_4010_0401}}))
        else $error("mode 13 pad set");
    en_single_a: assert property ((ok && sg)[*5] |-> lane_enable == 8'h0f)
        else $error("single lanes wrong");
    single_b_a: assert property ($rose(frame_valid) && sg && $past(sg, 4) |-> d[511:256] == 0)
        else $error("b lanes carry data");
    cover property (fresh(4'hb));
    cover property (fresh(4'hd));
    cover property (frame_valid && !frame_ready ##1 frame_valid);
endmodule // lsp_chk
bind lsp_lane_sample_packer lsp_chk lsp_chk_inst (.clk, .rst, .lane_map_mode, .dual_channel_pin,
    .lane_data, .lane_enable, .frame_valid, .frame_ready, .mode_error);

// file: lsp_lane_sample_packer.v
// lane sample packer: maps channel a/b samples onto eight lane frames
//
// Overview of operation
// - mode 11: 9-bit samples, 8 or 4 lanes
// - five 12-bit slots, msb first, tail nibble
// - lane k carries A k, k+4 ... k+16
// - dual parts: lanes 4-7 carry channel B
// - mode 12: one 8-bit sample per lane
// - mode 13: 10-bit slots, ten-nibble lane frame
`timescale 1ns/10ps
`include "lsp_map.vh"
module lsp_lane_sample_packer (
    input  wire                                  clk,
    input  wire                                  rst,
    input  wire [`LSP_MODE_W-1:0]                lane_map_mode,
    input  wire                                  dual_channel_pin,
    input  wire [`LSP_SAMPLE_W-1:0]              sample_a,
    input  wire [`LSP_SAMPLE_W-1:0]              sample_b,
    input  wire                                  sample_valid,
    output wire                                  sample_ready,
    output reg  [`LSP_LANES*`LSP_LANE_W-1:0]     lane_data,
    output reg  [`LSP_LANES-1:0]                 lane_enable,
    output reg                                   frame_valid,
    input  wire                                  frame_ready,
    output reg                                   mode_error
);
    localparam ST_OFF = 2'b01;
    localparam ST_RUN = 2'b10;

    reg  [1:0]                 state_reg;
    reg  [1:0]                 state_next;
    reg  [`LSP_MODE_W-1:0]     mode_reg;
    reg                        dual_meta_reg;
    reg                        dual_sync_reg;
    reg  [`LSP_CNT_W-1:0]      cnt_reg;
    reg  [`LSP_CNT_W-1:0]      last_idx;
    wire                       mode_ok;
    wire [2*`LSP_SAMPLE_W-1:0] buf_data;
    wire                       buf_valid;
    wire                       buf_ready;
    wire                       take;
    wire                       frame_done;
    wire [`LSP_ASM_W-1:0]      asm_next [0:`LSP_LANES-1];
    wire [`LSP_LANE_W-1:0]     lane_frame [0:`LSP_LANES-1];
    // lane index for the output register loop
    integer                    li;

    function mode_known;
        input [`LSP_MODE_W-1:0] m;
        begin
            mode_known = (m == `LSP_MODE_9B_8B10B) || (m == `LSP_MODE_8B_64B66B) ||
                         (m == `LSP_MODE_9B_TEN_NIB);
        end
    endfunction

    // one sample slot shifted in at the low end; msb-first falls out naturally
    function [`LSP_ASM_W-1:0] shift_slot;
        input [`LSP_MODE_W-1:0]   m;
        input [`LSP_ASM_W-1:0]    acc;
        input [`LSP_SAMPLE_W-1:0] s;
        begin
            case (m)
                `LSP_MODE_9B_8B10B: shift_slot = {acc[`LSP_ASM_W-13:0], s, `LSP_M11_PAD};
                `LSP_MODE_8B_64B66B: shift_slot = {acc[`LSP_ASM_W-9:0], s[8:1]};
                `LSP_MODE_9B_TEN_NIB: shift_slot = {acc[`LSP_ASM_W-11:0], s, `LSP_M13_PAD};
                default: shift_slot = acc;
            endcase
        end
    endfunction

    // final lane word: mode 11 adds the tail nibble, others sit in the low bits
    function [`LSP_LANE_W-1:0] close_frame;
        input [`LSP_MODE_W-1:0] m;
        input [`LSP_ASM_W-1:0]  acc;
        begin
            case (m)
                `LSP_MODE_9B_8B10B: close_frame = {acc[59:0], `LSP_M11_TAIL};
                `LSP_MODE_8B_64B66B: close_frame = {56'h0, acc[7:0]};
                `LSP_MODE_9B_TEN_NIB: close_frame = {24'h0, acc[39:0]};
                default: close_frame = {`LSP_LANE_W{1'b0}};
            endcase
        end
    endfunction

    // strap arrives from a pin, so it is synchronised before use
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dual_meta_reg <= 1'b0;
            dual_sync_reg <= 1'b0;
        end else begin
            dual_meta_reg <= dual_channel_pin;
            dual_sync_reg <= dual_meta_reg;
        end
    end

    // up to two pairs offered while no mode runs wait here and pack once one does
    lsp_pair_buf #(
        .WIDTH (2*`LSP_SAMPLE_W)
    ) lsp_pair_buf_inst (
        .clk       (clk),
        .rst       (rst),
        .in_data   ({sample_a, sample_b}),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    assign mode_ok = mode_known(mode_reg);
    always @* begin
        case (mode_reg)
            `LSP_MODE_9B_8B10B: last_idx = `LSP_M11_LAST;
            `LSP_MODE_8B_64B66B: last_idx = `LSP_M12_LAST;
            `LSP_MODE_9B_TEN_NIB: last_idx = `LSP_M13_LAST;
            default: last_idx = {`LSP_CNT_W{1'b0}};
        endcase
    end

    // a finished frame waits for the receiver; only the closing sample stalls
    assign buf_ready  = (state_reg == ST_RUN) &&
                        ((cnt_reg != last_idx) || !frame_valid || frame_ready);
    assign take       = buf_valid && buf_ready;
    assign frame_done = take && (cnt_reg == last_idx);

    genvar k;
    generate
        for (k = 0; k < `LSP_LANES; k = k + 1) begin : g_lane
            reg  [`LSP_ASM_W-1:0]    asm_reg;
            wire [`LSP_SAMPLE_W-1:0] chan_s;
            wire                     hit;
            // lanes 0-3 take channel a, 4-7 channel b, interleaved by four
            assign chan_s = (k < 4) ? buf_data[2*`LSP_SAMPLE_W-1:`LSP_SAMPLE_W]
                                    : buf_data[`LSP_SAMPLE_W-1:0];
            assign hit    = take && (cnt_reg[1:0] == k % 4);
            assign asm_next[k]   = hit ? shift_slot(mode_reg, asm_reg, chan_s) : asm_reg;
            assign lane_frame[k] = ((k < 4) || dual_sync_reg) ?
                                   close_frame(mode_reg, asm_next[k])
                                   : {`LSP_LANE_W{1'b0}};
            // no clear on a mode change: stale bits shift out before a frame closes
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    asm_reg <= {`LSP_ASM_W{1'b0}};
                end else begin
                    asm_reg <= asm_next[k];
                end
            end
        end
    endgenerate

    // one process owns the whole lane bus, so all lanes change on the same edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lane_data <= {(`LSP_LANES*`LSP_LANE_W){1'b0}};
        end else if (frame_done) begin
            for (li = 0; li < `LSP_LANES; li = li + 1) begin
                lane_data[li*`LSP_LANE_W +: `LSP_LANE_W] <= lane_frame[li];
            end
        end
    end

    // any mode change passes through off, so counting restarts in the new layout
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (mode_known(lane_map_mode)) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (lane_map_mode != mode_reg) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_OFF;
            mode_reg    <= {`LSP_MODE_W{1'b0}};
            cnt_reg     <= {`LSP_CNT_W{1'b0}};
            mode_error  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            mode_reg   <= lane_map_mode;
            mode_error <= !mode_known(lane_map_mode);
            // a mode change drops the partial frame rather than mixing layouts
            if (state_next != ST_RUN) begin
                cnt_reg <= {`LSP_CNT_W{1'b0}};
            end else if (take) begin
                cnt_reg <= (cnt_reg == last_idx) ? {`LSP_CNT_W{1'b0}}
                                                 : cnt_reg + 5'h01;
            end
        end
    end

    // a frame completing in the accept cycle keeps frame_valid up
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_valid <= 1'b0;
        end else if (frame_done) begin
            frame_valid <= 1'b1;
        end else if (frame_ready || state_reg != ST_RUN) begin
            frame_valid <= 1'b0;
        end
    end

    // b lanes follow the synchronised strap, three cycles behind the pin
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lane_enable <= {`LSP_LANES{1'b0}};
        end else if (mode_ok && state_reg == ST_RUN) begin
            lane_enable <= {{4{dual_sync_reg}}, 4'hf};
        end else begin
            lane_enable <= {`LSP_LANES{1'b0}};
        end
    end
endmodule // lsp_lane_sample_packer

// file: lsp_map.vh
// constants for the lane sample packer
`ifndef LSP_MAP_VH
`define LSP_MAP_VH
`define LSP_MODE_W          4
`define LSP_MODE_9B_8B10B   4'hb
`define LSP_MODE_8B_64B66B  4'hc
`define LSP_MODE_9B_TEN_NIB 4'hd
`define LSP_SAMPLE_W        9
`define LSP_LANES           8
`define LSP_LANE_W          64
`define LSP_ASM_W           64
`define LSP_CNT_W           5
`define LSP_M11_SLOT_W      12
`define LSP_M12_SLOT_W      8
`define LSP_M13_SLOT_W      10
`define LSP_M11_LAST        5'h13
`define LSP_M12_LAST        5'h03
`define LSP_M13_LAST        5'h0f
`define LSP_M11_PAD         3'h0
`define LSP_M13_PAD         1'h0
`define LSP_M11_TAIL        4'h0
`define LSP_BUF_DEPTH       2
`endif

// file: lsp_pair_buf.v
// two-entry sample buffer with valid/ready on both sides
`timescale 1ns/10ps
module lsp_pair_buf #(
    parameter WIDTH = 18
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg  [WIDTH-1:0] spare_reg;
    reg              spare_full_reg;
    wire             push;
    wire             pop;

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    // out_data is the head register, spare_reg the second entry
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_data       <= {WIDTH{1'b0}};
            out_valid      <= 1'b0;
            spare_reg      <= {WIDTH{1'b0}};
            spare_full_reg <= 1'b0;
            in_ready       <= 1'b1;
        end else begin
            if (pop || !out_valid) begin
                if (spare_full_reg) begin
                    out_data       <= spare_reg;
                    out_valid      <= 1'b1;
                    spare_full_reg <= push;
                    if (push) begin
                        spare_reg <= in_data;
                    end
                    in_ready <= 1'b1;
                end else begin
                    out_valid <= push;
                    if (push) begin
                        out_data <= in_data;
                    end
                    in_ready <= 1'b1;
                end
            end else if (push) begin
                // head stalled: second entry fills, so no word is lost
                spare_reg      <= in_data;
                spare_full_reg <= 1'b1;
                in_ready       <= 1'b0;
            end
        end
    end
endmodule // lsp_pair_buf

// file: lsp_rx_model.sv
// frame receiver model with prompt or throttled acceptance
`timescale 1ns/10ps
module lsp_rx_model (
    input  wire         clk,
    input  wire         rst,
    input  wire         slow,
    input  wire         frame_valid,
    input  wire [511:0] lane_data,
    output wire         frame_ready,
    output reg  [511:0] got_data_reg,
    output reg  [7:0]   got_cnt_reg
);
    reg [2:0] tick_reg;
    reg       ready_reg;
    assign frame_ready = ready_reg;
    // throttled: open one cycle in eight, so the packer must hold frames
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_reg <= 3'h0;
            ready_reg <= 1'b0;
            got_cnt_reg <= 8'h00;
            got_data_reg <= 512'h0;
        end else begin
            tick_reg <= tick_reg + 3'h1;
            ready_reg <= !slow || tick_reg == 3'h6;
            if (frame_valid && ready_reg) begin
                got_data_reg <= lane_data;
                got_cnt_reg <= got_cnt_reg + 8'h01;
            end
        end
    end
endmodule // lsp_rx_model

// file: test_lane_sample_packer.sv
// self-checking testbench for the lane sample packer
`timescale 1ns/10ps
module test_lane_sample_packer;
    reg          clk, rst, dual, valid, slow;
    reg  [3:0]   mode;
    reg  [8:0]   sa, sb;
    wire         ready, fv, fr, merr;
    wire [511:0] ld, got;
    wire [7:0]   en, gcnt;
    integer      n_mismatch, checked, stalls;
    lsp_lane_sample_packer lsp_lane_sample_packer_inst (.clk(clk), .rst(rst),
        .lane_map_mode(mode), .dual_channel_pin(dual), .sample_a(sa), .sample_b(sb),
        .sample_valid(valid), .sample_ready(ready), .lane_data(ld), .lane_enable(en),
        .frame_valid(fv), .frame_ready(fr), .mode_error(merr));
    lsp_rx_model lsp_rx_model_inst (.clk(clk), .rst(rst), .slow(slow), .frame_valid(fv),
        .lane_data(ld), .frame_ready(fr), .got_data_reg(got), .got_cnt_reg(gcnt));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    function [8:0] smp(input integer i, input integer ch);
        smp = ch ? 9'h1a5 - i[8:0] : 9'h03c + i[8:0] * 9'h1d;
    endfunction
    function [511:0] expf(input [3:0] m, input integer d, input integer base);
        integer k, s;
        reg [8:0] v;
        begin
            expf = 0;
            for (k = 0; k < 8; k = k + 1)
                for (s = 0; s < 5; s = s + 1) begin
                    v = smp(base + k % 4 + 4 * s, k / 4);
                    if (k < 4 || d)
                        case (m)
                        4'hb: expf[64*k+63-12*s -: 12] = {v, 3'h0};
                        4'hc: if (s == 0) expf[64*k +: 8] = v[8:1];
                        default: if (s < 4) expf[64*k+39-10*s -: 10] = {v, 1'b0};
                        endcase
                end
        end
    endfunction
    task chk(input [511:0] exp, input [511:0] seen, input [63:0] what);
        begin
            checked = checked + 1;
            if (exp !== seen) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task setm(input [3:0] m, input d);
        begin
            mode = m;
            dual = d;
            repeat (8) @(posedge clk);
            #1;
        end
    endtask
    // holds each pair until an edge sees ready high
    task put(input integer n, input integer base);
        integer i;
        reg r;
        begin
            for (i = 0; i < n; i = i + 1) begin
                sa = smp(base + i, 0);
                sb = smp(base + i, 1);
                valid = 1;
                r = 0;
                while (!r) begin
                    r = ready;
                    if (!r) stalls = stalls + 1;
                    @(posedge clk);
                    #1;
                end
            end
            valid = 0;
        end
    endtask
    task getf(input [3:0] m, input integer d, input integer base);
        integer t;
        reg [7:0] c;
        begin
            c = gcnt;
            for (t = 0; t < 300 && gcnt === c; t = t + 1) begin
                @(posedge clk);
                #1;
            end
            if (gcnt === c) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] frame count expected %0d seen %0d", c + 8'h01, gcnt);
            end
            chk(expf(m, d, base), got, "lanes");
        end
    endtask
    task t_m11;
        begin
            setm(4'hb, 1);
            fork put(20, 0); getf(4'hb, 1, 0); join
            chk(8'hff, en, "enable");
            $display("done mode 11 dual");
        end
    endtask
    task t_m12;
        begin
            setm(4'hc, 0);
            slow = 1;
            stalls = 0;
            fork
                put(12, 0);
                begin getf(4'hc, 0, 0); getf(4'hc, 0, 4); getf(4'hc, 0, 8); end
            join
            slow = 0;
            chk(1, stalls > 0, "refused");
            chk(8'h0f, en, "enable");
            $display("done mode 12 single stalled");
        end
    endtask
    task t_m13;
        begin
            setm(4'hd, 1);
            fork put(16, 40); getf(4'hd, 1, 40); join
            $display("done mode 13 dual");
        end
    endtask
    task t_bad;
        reg [7:0] c;
        begin
            setm(4'h5, 1);
            c = gcnt;
            chk(9'h100, {merr, en}, "bad mode");
            valid = 1;
            repeat (8) @(posedge clk);
            #1;
            chk({1'b0, c}, {ready, gcnt}, "refused");
            valid = 0;
            rst = 1;
            @(posedge clk);
            #1;
            rst = 0;
            chk(1, ready, "ready");
            $display("done bad mode and reset");
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #40000;
        n_mismatch = n_mismatch + 1;
        conclude;
    end
    initial begin
        {dual, valid, slow, mode, sa, sb} = 0;
        rst = 1;
        n_mismatch = 0;
        checked = 0;
        stalls = 0;
        repeat (3) @(posedge clk);
        #1;
        rst = 0;
        t_m11;
        t_m12;
        t_m13;
        t_bad;
        conclude;
    end
endmodule // test_lane_sample_packer
